// ==== logic/diag_led_map.svh ====
`ifndef DIAG_LED_MAP_SVH
`define DIAG_LED_MAP_SVH

// register byte offsets
`define OFS_POST_CODE 8'h00
`define OFS_CONTROL 8'h04
`define OFS_BOOT_PHASE 8'h08
`define OFS_MEM_FAULT 8'h0C
`define OFS_LED_STATUS 8'h10
`define OFS_INT_STATUS 8'h14
`define OFS_INT_MASK 8'h18

// control register fields
`define CTL_IDENT_BIT 0
`define CTL_HEALTH_LSB 1

// health modes
`define HEALTH_GREEN 2'h0
`define HEALTH_GREEN_BLINK 2'h1
`define HEALTH_AMBER 2'h2
`define HEALTH_AMBER_BLINK 2'h3

// interrupt status bits
`define INT_BUTTON 0
`define INT_IDENT_END 1
`define INT_CPU_FAULT 2
`define INT_FAN_FAULT 3
`define INT_RESTART 4

// timing
`define CLK_HZ 50000000
`define BLINK_FAST_HZ 6
`define TICK_HZ (2 * `BLINK_FAST_HZ)
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define ID_BLINK_S 120
`define ID_BLINK_TICKS (`ID_BLINK_S * `TICK_HZ)

// reset values
`define POST_RESET 8'h00
`define HEALTH_RESET 2'h0

`endif

// ==== logic/diag_led_pkg.sv ====
package diag_led_pkg;

  // controller boot phases, one-hot
  typedef enum logic [4:0] {
    BOOT_LOADER = 5'h01,
    BOOT_OS = 5'h02,
    BOOT_DONE = 5'h04,
    BOOT_MEMFAIL = 5'h08,
    BOOT_NOIMG = 5'h10
  } boot_t;

  // every indicator driven by the block
  typedef struct packed {
    logic [7:0] post;
    logic id_board;
    logic id_front;
    logic grn_board;
    logic amb_board;
    logic grn_front;
    logic amb_front;
    logic [1:0] cpu;
    logic [15:0] mem;
    logic [5:0] fan;
  } led_t;

  // whole state of the controller
  typedef struct packed {
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] post;
    logic [1:0] health;
    boot_t boot;
    logic [15:0] mem;
    logic [4:0] int_st;
    logic [4:0] int_mask;
    logic id_on;
    logic [10:0] id_cnt;
    logic [22:0] tick_cnt;
    logic [3:0] phase;
    logic [5:0] fan_latch;
    logic [1:0] cpu_prev;
    led_t led;
  } state_t;

endpackage

// ==== logic/diag_led_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "diag_led_map.svh"

module diag_led_ctrl #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rear_btn,
  input wire logic front_btn,
  input wire logic ctrl_restart,
  input wire logic sys_power_on,
  input wire logic dc_power_on,
  input wire logic sys_reset,
  input wire logic [1:0] power_rating_identifier_mismatch,
  input wire logic [5:0] fan_tach_low,
  output diag_led_pkg::led_t led,
  output logic irq
);
  import diag_led_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  state_t s_q;
  state_t s_d;
  logic wr_fire;
  logic rd_fire;
  logic tick;
  logic ident_req;
  logic press;
  logic rearm;
  logic [31:0] wmerge;
  logic [31:0] rd_val;
  logic rd_ok;
  logic blink6;
  logic blink3;
  logic blink1;
  logic id_out;
  logic grn_out;
  logic amb_out;
  logic [4:0] ev;

  // merge write data into an old value under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // handshake outputs straight from the held state; one write and one read in flight
  assign awready = !s_q.aw_hold && !s_q.bvalid;
  assign wready = !s_q.w_hold && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign led = s_q.led;
  assign irq = |(s_q.int_st & s_q.int_mask);
  assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign rd_fire = arvalid && !s_q.rvalid;

  // ==========================================================================
  // next-state logic
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    ev = 5'h00;
    // address and data may arrive in either order; each is held until both are in
    if (awvalid && awready) begin
      s_d.aw_hold = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_hold = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end

    // blink time base: one tick per half period of the fastest rate
    tick = (s_q.tick_cnt == 23'(TICK_CYCLES - 1));
    s_d.tick_cnt = tick ? 23'h000000 : s_q.tick_cnt + 23'h000001;
    if (tick) begin
      s_d.phase = (s_q.phase == 4'hB) ? 4'h0 : s_q.phase + 4'h1;
    end
    blink6 = s_q.phase[0];
    blink3 = s_q.phase[1];
    blink1 = (s_q.phase < 4'h6);

    // register writes
    wmerge = 32'h00000000;
    ident_req = 1'b0;
    if (wr_fire) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      unique case (s_q.awaddr)
        `OFS_POST_CODE: begin
          wmerge = merge({24'h000000, s_q.post}, s_q.wdata, s_q.wstrb);
          s_d.post = wmerge[7:0];
        end
        `OFS_CONTROL: begin
          wmerge = merge({29'h00000000, s_q.health, 1'b0}, s_q.wdata, s_q.wstrb);
          s_d.health = wmerge[`CTL_HEALTH_LSB +: 2];
          ident_req = wmerge[`CTL_IDENT_BIT];
        end
        `OFS_BOOT_PHASE: begin
          wmerge = merge({27'h0000000, s_q.boot}, s_q.wdata, s_q.wstrb);
          // fatal phases are held until power is removed; illegal codes are ignored
          if (s_q.boot != BOOT_MEMFAIL && s_q.boot != BOOT_NOIMG) begin
            unique case (wmerge[4:0])
              BOOT_LOADER, BOOT_OS, BOOT_DONE, BOOT_MEMFAIL, BOOT_NOIMG: s_d.boot = boot_t'(wmerge[4:0]);
              default: s_d.boot = s_q.boot;
            endcase
          end
        end
        `OFS_MEM_FAULT: begin
          // slot LEDs only ever follow what host firmware asks
          wmerge = merge({16'h0000, s_q.mem}, s_q.wdata, s_q.wstrb);
          s_d.mem = wmerge[15:0];
        end
        `OFS_INT_STATUS: begin
          s_d.int_st = s_q.int_st & ~(s_q.wdata[4:0] & {5{s_q.wstrb[0]}});
        end
        `OFS_INT_MASK: begin
          wmerge = merge({27'h0000000, s_q.int_mask}, s_q.wdata, s_q.wstrb);
          s_d.int_mask = wmerge[4:0];
        end
        `OFS_LED_STATUS: begin
          s_d.bresp = 2'h0;
        end
        default: begin
          s_d.bresp = 2'h2;
        end
      endcase
    end

    // a controller restart reruns the boot display unless a fatal phase is held; DC power cycles do not
    if (ctrl_restart && s_q.boot != BOOT_MEMFAIL && s_q.boot != BOOT_NOIMG) begin
      s_d.boot = BOOT_LOADER;
      ev[`INT_RESTART] = 1'b1;
    end

    // identify: buttons toggle one shared state; a press also ends a timed blink
    press = rear_btn ^ front_btn;
    if (press) begin
      s_d.id_on = !s_q.id_on;
      s_d.id_cnt = 11'h000;
      ev[`INT_BUTTON] = 1'b1;
    end else if (ident_req) begin
      s_d.id_cnt = 11'(`ID_BLINK_TICKS);
    end else if (tick && s_q.id_cnt != 11'h000) begin
      s_d.id_cnt = s_q.id_cnt - 11'h001;
      ev[`INT_IDENT_END] = (s_q.id_cnt == 11'h001);
    end

    // fan latches: rearm reloads from the live level so a standing fault stays lit
    rearm = dc_power_on || sys_reset;
    if (rearm) begin
      s_d.fan_latch = fan_tach_low;
    end else begin
      s_d.fan_latch = s_q.fan_latch | fan_tach_low;
    end
    ev[`INT_FAN_FAULT] = |(fan_tach_low & ~s_q.fan_latch);
    ev[`INT_CPU_FAULT] = |(power_rating_identifier_mismatch & ~s_q.cpu_prev);
    s_d.cpu_prev = power_rating_identifier_mismatch;

    // sticky status: a new event beats a clear in the same cycle
    s_d.int_st = s_d.int_st | ev;

    // indicator patterns per boot phase
    id_out = 1'b0;
    grn_out = 1'b0;
    amb_out = 1'b0;
    unique case (s_q.boot)
      BOOT_MEMFAIL: begin
        id_out = 1'b1;
        amb_out = 1'b1;
      end
      BOOT_NOIMG: begin
        id_out = blink6;
        amb_out = 1'b1;
      end
      BOOT_LOADER: begin
        id_out = blink3;
        grn_out = blink1;
      end
      BOOT_OS: begin
        id_out = 1'b1;
        grn_out = 1'b1;
      end
      BOOT_DONE: begin
        // steady identify wins over a timed blink
        id_out = s_q.id_on || (s_q.id_cnt != 11'h000 && blink1);
        unique case (s_q.health)
          `HEALTH_GREEN: grn_out = 1'b1;
          `HEALTH_GREEN_BLINK: grn_out = blink1;
          `HEALTH_AMBER: amb_out = 1'b1;
          `HEALTH_AMBER_BLINK: amb_out = blink1;
        endcase
      end
    endcase
    s_d.led.post = s_q.post;
    s_d.led.id_board = id_out;
    s_d.led.id_front = id_out;
    s_d.led.grn_board = grn_out;
    s_d.led.amb_board = amb_out;
    s_d.led.grn_front = grn_out;
    s_d.led.amb_front = amb_out;
    // fault LEDs stay quiet until the controller has finished booting
    s_d.led.cpu = (s_q.boot == BOOT_DONE) ? power_rating_identifier_mismatch : 2'h0;
    s_d.led.mem = (s_q.boot == BOOT_DONE && sys_power_on) ? s_q.mem : 16'h0000;
    s_d.led.fan = (s_q.boot == BOOT_DONE) ? s_q.fan_latch : 6'h00;

    // register reads answer one cycle after the address is taken
    rd_ok = 1'b1;
    unique case (araddr)
      `OFS_POST_CODE: rd_val = {24'h000000, s_q.post};
      `OFS_CONTROL: rd_val = {29'h00000000, s_q.health, 1'b0};
      `OFS_BOOT_PHASE: rd_val = {27'h0000000, s_q.boot};
      `OFS_MEM_FAULT: rd_val = {16'h0000, s_q.mem};
      `OFS_LED_STATUS: rd_val = {19'h00000, s_q.fan_latch, s_q.led.cpu, s_q.led.amb_board,
                                 s_q.led.grn_board, s_q.led.id_board, (s_q.id_cnt != 11'h000), s_q.id_on};
      `OFS_INT_STATUS: rd_val = {27'h0000000, s_q.int_st};
      `OFS_INT_MASK: rd_val = {27'h0000000, s_q.int_mask};
      default: begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_ok ? 2'h0 : 2'h2;
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  // an AC power-up is the reset, which starts the boot display in the loader phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.post <= `POST_RESET;
      s_q.health <= `HEALTH_RESET;
      s_q.boot <= BOOT_LOADER;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_post_code;
    wr_fire && s_q.awaddr == `OFS_POST_CODE && s_q.wstrb[0] |-> ##2 led.post == $past(s_q.wdata[7:0], 2);
  endproperty
  a_post_code: assert property (p_post_code) else $error("progress code not shown");

  property p_rear_on;
    rear_btn && !front_btn && !s_q.id_on && s_q.boot == BOOT_DONE && !ctrl_restart |-> ##2 led.id_board;
  endproperty
  a_rear_on: assert property (p_rear_on) else $error("rear press did not light identify");

  property p_front_off;
    front_btn && !rear_btn && s_q.id_on && s_q.boot == BOOT_DONE && !ctrl_restart |-> ##2 !led.id_board;
  endproperty
  a_front_off: assert property (p_front_off) else $error("front press did not clear identify");

  property p_ident_limit;
    s_q.id_cnt <= 11'(`ID_BLINK_TICKS);
  endproperty
  a_ident_limit: assert property (p_ident_limit) else $error("identify blink longer than limit");

  property p_id_shared;
    led.id_board == led.id_front;
  endproperty
  a_id_shared: assert property (p_id_shared) else $error("identify LEDs differ");

  property p_health_mirror;
    led.grn_board == led.grn_front && led.amb_board == led.amb_front;
  endproperty
  a_health_mirror: assert property (p_health_mirror) else $error("front health differs");

  property p_memfail;
    s_q.boot == BOOT_MEMFAIL |=> s_q.boot == BOOT_MEMFAIL && led.id_board && led.amb_board && !led.grn_board;
  endproperty
  a_memfail: assert property (p_memfail) else $error("memory test fault not held");

  property p_loader_slow;
    s_q.boot == BOOT_LOADER && $stable(s_q.boot) && !ctrl_restart |=> !led.amb_board;
  endproperty
  a_loader_slow: assert property (p_loader_slow) else $error("amber in loader phase");

  property p_restart;
    ctrl_restart && s_q.boot != BOOT_MEMFAIL && s_q.boot != BOOT_NOIMG |=> s_q.boot == BOOT_LOADER;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not rerun boot display");

  property p_cpu_led;
    s_q.boot == BOOT_DONE |=> led.cpu == $past(power_rating_identifier_mismatch);
  endproperty
  a_cpu_led: assert property (p_cpu_led) else $error("socket fault LED wrong");

  property p_mem_dark;
    !sys_power_on |=> led.mem == 16'h0000;
  endproperty
  a_mem_dark: assert property (p_mem_dark) else $error("memory LED lit while off");

  property p_fan_latch;
    !dc_power_on && !sys_reset |=> (s_q.fan_latch & $past(fan_tach_low)) == $past(fan_tach_low);
  endproperty
  a_fan_latch: assert property (p_fan_latch) else $error("fan fault not latched");

  property p_phase_range;
    s_q.phase < 4'hC;
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("blink phase out of range");

  c_memfail: cover property (s_q.boot == BOOT_MEMFAIL);
  c_ident_blink: cover property (s_q.id_cnt != 11'h000 && led.id_board);
  c_fan_latched: cover property (led.fan != 6'h00);
  c_boot_done: cover property (s_q.boot == BOOT_DONE && led.grn_board);

endmodule
`default_nettype wire

// ==== tb/evt_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// far side: identify buttons, controller restart, system power events
module evt_model (
  input wire logic aclk,
  input wire logic [2:0] cmd,
  output logic rear_btn,
  output logic front_btn,
  output logic ctrl_restart,
  output logic dc_power_on,
  output logic sys_reset
);
  // debounced presses arrive as one-cycle pulses; the bench holds cmd for one cycle only
  always_ff @(posedge aclk) begin
    rear_btn <= (cmd == 3'h1);
    front_btn <= (cmd == 3'h2);
    ctrl_restart <= (cmd == 3'h3);
    dc_power_on <= (cmd == 3'h4);
    sys_reset <= (cmd == 3'h5);
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import diag_led_pkg::*;
  // short tick keeps blink periods between 8 and 48 cycles
  localparam int unsigned TC = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic sys_power_on = 1'b0;
  logic [1:0] mis = 2'h0;
  logic [5:0] tach = 6'h00;
  logic [2:0] cmd = 3'h0;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic rear_btn, front_btn, ctrl_restart, dc_power_on, sys_reset;
  wire logic [1:0] bresp;
  wire logic [1:0] rresp;
  wire logic [31:0] rdata;
  led_t led;
  logic [1:0] rsp;
  logic [31:0] rv;
  int error_cnt = 0;
  int comparisons = 0;

  always #10 aclk = ~aclk;

  diag_led_ctrl #(.TICK_CYCLES(TC)) diag_led_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .rear_btn(rear_btn), .front_btn(front_btn), .ctrl_restart(ctrl_restart), .sys_power_on(sys_power_on),
    .dc_power_on(dc_power_on), .sys_reset(sys_reset), .power_rating_identifier_mismatch(mis),
    .fan_tach_low(tach), .led(led), .irq(irq));
  evt_model evt_model_i (.aclk(aclk), .cmd(cmd), .rear_btn(rear_btn), .front_btn(front_btn),
    .ctrl_restart(ctrl_restart), .dc_power_on(dc_power_on), .sys_reset(sys_reset));

  // =====================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each dropped once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic t;
    t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(posedge aclk);
      if (arready) begin
        t = 1'b1;
        arvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] c);
    @(posedge aclk);
    cmd <= c;
    @(posedge aclk);
    cmd <= 3'h0;
    cyc(4);
  endtask

  // 48 cycles is a whole number of periods of every blink, so halves count exactly
  task automatic smp(output int ci, output int cg, output int ca);
    int mm;
    ci = 0;
    cg = 0;
    ca = 0;
    mm = 0;
    repeat (48) begin
      @(posedge aclk);
      ci += led.id_board;
      cg += led.grn_board;
      ca += led.amb_board;
      if (led.id_front !== led.id_board || led.grn_front !== led.grn_board || led.amb_front !== led.amb_board)
        mm++;
    end
    chk(mm, 0);
  endtask

  task automatic lk(input int ei, input int eg, input int ea);
    int ci, cg, ca;
    smp(ci, cg, ca);
    chk(ci, ei);
    chk(cg, eg);
    chk(ca, ea);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =====================================================
  // scenarios
  task automatic t_post;
    rd(8'h00);
    chk(rv, 32'h0);
    chk(irq, 1'b0);
    wr(8'h00, 32'h000000A5);
    chk(rsp, 2'h0);
    cyc(3);
    chk(led.post, 8'hA5);
    rd(8'h00);
    chk(rv, 32'h000000A5);
    rd(8'h1C);
    chk(rsp, 2'h2);
    wr(8'h1C, 32'h1);
    chk(rsp, 2'h2);
    lk(24, 24, 0);
    $display("test post and loader done");
  endtask

  task automatic t_boot;
    int ci, cg, ca, v, o;
    wr(8'h08, 32'h2);
    cyc(4);
    lk(48, 48, 0);
    wr(8'h08, 32'h4);
    for (int m = 0; m < 4; m++) begin
      wr(8'h04, 32'(m << 1));
      cyc(4);
      smp(ci, cg, ca);
      v = m[1] ? ca : cg;
      o = m[1] ? cg : ca;
      chk(ci, 0);
      chk(o, 0);
      chk(v, m[0] ? 24 : 48);
    end
    wr(8'h04, 32'h0);
    $display("test boot phases done");
  endtask

  task automatic t_btn;
    wr(8'h18, 32'h1);
    pulse(3'h1);
    chk(led.id_board, 1'b1);
    chk(irq, 1'b1);
    rd(8'h14);
    chk(rv, 32'h1);
    wr(8'h14, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    pulse(3'h2);
    chk(led.id_board, 1'b0);
    pulse(3'h2);
    chk({led.id_board, led.id_front}, 2'h3);
    pulse(3'h1);
    chk(led.id_front, 1'b0);
    wr(8'h18, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    wr(8'h14, 32'h1F);
    $display("test buttons done");
  endtask

  task automatic t_ident;
    time t0;
    int e;
    wr(8'h04, 32'h1);
    t0 = $time;
    rd(8'h10);
    chk(rv[1], 1'b1);
    lk(24, 48, 0);
    do rd(8'h10); while (rv[1] === 1'b1);
    e = int'(($time - t0) / 20);
    chk(e >= 5740 && e <= 5790, 1);
    cyc(4);
    chk(led.id_board, 1'b0);
    rd(8'h14);
    chk(rv[1], 1'b1);
    wr(8'h14, 32'h1F);
    $display("test identify done");
  endtask

  task automatic t_fault;
    @(posedge aclk);
    mis <= 2'h2;
    cyc(4);
    chk(led.cpu, 2'h2);
    mis <= 2'h0;
    cyc(4);
    chk(led.cpu, 2'h0);
    sys_power_on <= 1'b1;
    wr(8'h0C, 32'h0010);
    cyc(40);
    chk(led.mem, 16'h0010);
    sys_power_on <= 1'b0;
    cyc(3);
    chk(led.mem, 16'h0000);
    sys_power_on <= 1'b1;
    tach <= 6'h04;
    cyc(1);
    tach <= 6'h00;
    cyc(4);
    chk(led.fan, 6'h04);
    pulse(3'h4);
    chk(led.fan, 6'h00);
    chk({led.id_board, led.grn_board}, 2'h1);
    tach <= 6'h04;
    pulse(3'h5);
    chk(led.fan, 6'h04);
    tach <= 6'h00;
    pulse(3'h5);
    chk(led.fan, 6'h00);
    $display("test fault leds done");
  endtask

  task automatic t_halt;
    mis <= 2'h1;
    pulse(3'h3);
    lk(24, 24, 0);
    chk(led.cpu, 2'h0);
    // socket rise, fan faults and the restart itself are all pending, nothing else
    rd(8'h14);
    chk(rv, 32'h0000001C);
    mis <= 2'h0;
    wr(8'h08, 32'h8);
    cyc(4);
    lk(48, 0, 48);
    wr(8'h08, 32'h4);
    cyc(4);
    lk(48, 0, 48);
    aresetn <= 1'b0;
    cyc(16);
    aresetn <= 1'b1;
    wr(8'h08, 32'h10);
    cyc(4);
    lk(24, 0, 48);
    $display("test halt states done");
  endtask

  // =====================================================
  // main sequence and watchdog
  initial begin
    cyc(16);
    aresetn <= 1'b1;
    t_post();
    t_boot();
    t_btn();
    t_ident();
    t_fault();
    t_halt();
    end_sim();
  end

  // the whole run needs about 6600 cycles, most of them spent waiting out the identify blink
  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
